// file: los_pattern_pkg.sv
// package: register map, field layout, reset values and pattern codes
//
// Operation
// - pll unlock reaches loss pin when enabled
// - per-lane sync loss reaches loss pin when enabled
// - per-lane bad code reaches loss pin when enabled
// - per-lane signal loss reaches loss pin when enabled
// - fast generation enable starts selected pattern
// - fast check enable starts checking selected pattern
// - fast codes 000-100 are h/l/m/crpat patterns
// - fast codes 101-111 are prbs, default 101
// - fast check errors accumulate in error tally
// - slow generation enable starts selected pattern
// - slow check enable starts checking selected pattern
// - slow choice is bit 11 over bits 5:4
// - slow codes 000-100 are h/l/m/crpat patterns
// - slow codes 101-111 are prbs, default 101
`default_nettype none
package los_pattern_pkg;
    // register offsets
    localparam logic [4:0] ADDR_OVERLAY = 5'h0a;
    localparam logic [4:0] ADDR_PATTERN = 5'h0b;
    localparam logic [4:0] ADDR_ERR_TALLY = 5'h0e;
    localparam logic [15:0] RST_OVERLAY = 16'h4000;
    localparam logic [15:0] RST_PATTERN = 16'h0d10;
    // overlay field positions
    localparam int POS_PLL = 12;
    localparam int POS_SYNC = 8;
    localparam int POS_CODE = 4;
    localparam int POS_SIG = 0;
    // pattern control field positions
    localparam int POS_FGEN = 13;
    localparam int POS_FCHK = 12;
    localparam int POS_SSEL_HI = 11;
    localparam int POS_FSEL = 8;
    localparam int POS_SGEN = 7;
    localparam int POS_SCHK = 6;
    localparam int POS_SSEL_LO = 4;
    // management frame
    localparam logic [1:0] ST_CL45 = 2'b00;
    localparam logic [1:0] OP_ADDR = 2'b00;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [1:0] OP_READ = 2'b11;
    localparam logic [1:0] OP_RINC = 2'b10;
    localparam logic [4:0] DEV_ADDR = 5'h1e;
    localparam logic [4:0] PORT_ADDR_DFLT = 5'h00;
    localparam logic [5:0] FRAME_BITS = 6'd32;
    // pattern codes
    typedef enum logic [2:0] {
        PAT_HIGH = 3'h0, PAT_LOW = 3'h1, PAT_MIXED = 3'h2, PAT_CRPAT_LONG = 3'h3,
        PAT_CRPAT_SHORT = 3'h4, PAT_PRBS7 = 3'h5, PAT_PRBS23 = 3'h6, PAT_PRBS31 = 3'h7
    } pattern_code_t;
    // per-channel slow side conditions
    typedef struct packed {
        logic pll_unlock;
        logic [3:0] sync_loss;
        logic [3:0] bad_code;
        logic [3:0] signal_loss;
    } slow_status_t;
    // decoded pattern controls
    typedef struct packed {
        logic fast_pattern_gen_on;
        logic fast_pattern_check_on;
        pattern_code_t fast_pattern_choice;
        logic fast_prbs;
        logic slow_pattern_gen_on;
        logic slow_pattern_check_on;
        pattern_code_t slow_pattern_choice;
        logic slow_crpat;
    } pattern_ctrl_t;

    // true for codes that need a non-kr mode
    function automatic logic is_crpat(input logic [2:0] c);
        return (c == PAT_CRPAT_LONG) || (c == PAT_CRPAT_SHORT);
    endfunction : is_crpat

    function automatic logic is_prbs(input logic [2:0] c);
        return c >= PAT_PRBS7;
    endfunction : is_prbs
endpackage : los_pattern_pkg
`default_nettype wire

// file: mdio_slave.sv
// mdio clause-45 slave: frame decode, register read and write strobes
`default_nettype none
module mdio_slave (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic mdc_i,
    input wire logic mdio_in_i,
    input wire logic [4:0] port_addr_i,
    input wire logic [15:0] rd_data_i,
    output logic mdio_out_o,
    output logic mdio_oe_o,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] reg_addr_o,
    output logic [15:0] wr_data_o
);
    logic [1:0] mdc_s_r;
    logic [1:0] mdi_s_r;
    logic mdc_d_r;
    logic [5:0] preamble_r;
    logic [5:0] cnt_r;
    logic active_r;
    logic [31:0] sh_r;
    logic [15:0] rd_sh_r;
    logic [15:0] addr_r;
    logic mine_r;
    logic rd_op_r;

    wire rise = mdc_s_r[1] & ~mdc_d_r;
    wire fall = ~mdc_s_r[1] & mdc_d_r;
    wire bit_in = mdi_s_r[1];
    wire [31:0] sh_nxt = {sh_r[30:0], bit_in};
    // header complete after 14 bits: st(2) op(2) prtad(5) devad(5)
    wire hdr_done = active_r && cnt_r == 6'd13 && rise;
    wire [1:0] hdr_op = sh_nxt[11:10];
    wire hdr_mine = sh_nxt[13:12] == los_pattern_pkg::ST_CL45 &&
        sh_nxt[9:5] == port_addr_i && sh_nxt[4:0] == los_pattern_pkg::DEV_ADDR;
    wire frame_end = active_r && cnt_r == los_pattern_pkg::FRAME_BITS - 6'd1 && rise;
    wire [1:0] fop = sh_nxt[29:28];

    // pins through two flops, both stages local only
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mdc_s_r <= 2'b00;
            mdi_s_r <= 2'b11;
            mdc_d_r <= 1'b0;
        end else begin
            mdc_s_r <= {mdc_s_r[0], mdc_i};
            mdi_s_r <= {mdi_s_r[0], mdio_in_i};
            mdc_d_r <= mdc_s_r[1];
        end
    end

    // frame counter: 32 ones of preamble then a zero start bit arms the frame
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            preamble_r <= 6'd0;
            cnt_r <= 6'd0;
            active_r <= 1'b0;
            sh_r <= 32'h0;
        end else if (rise) begin
            sh_r <= sh_nxt;
            if (!active_r) begin
                preamble_r <= bit_in ? ((preamble_r == 6'd32) ? preamble_r : preamble_r + 6'd1)
                                     : 6'd0;
                if (!bit_in && preamble_r == 6'd32) begin
                    active_r <= 1'b1;
                    cnt_r <= 6'd1;
                end
            end else if (frame_end) begin
                active_r <= 1'b0;
                cnt_r <= 6'd0;
            end else begin
                cnt_r <= cnt_r + 6'd1;
            end
        end
    end

    // address latch, read data shifter and strobes
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_r <= 16'h0;
            mine_r <= 1'b0;
            rd_op_r <= 1'b0;
            rd_sh_r <= 16'h0;
            mdio_out_o <= 1'b0;
            mdio_oe_o <= 1'b0;
            wr_o <= 1'b0;
            rd_o <= 1'b0;
            wr_data_o <= 16'h0;
        end else begin
            wr_o <= 1'b0;
            rd_o <= 1'b0;
            if (hdr_done) begin
                mine_r <= hdr_mine;
                rd_op_r <= hdr_mine && (hdr_op == los_pattern_pkg::OP_READ ||
                                        hdr_op == los_pattern_pkg::OP_RINC);
                // capture with the strobe: a clear-on-read target still returns its old value
                if (hdr_mine && (hdr_op == los_pattern_pkg::OP_READ ||
                                 hdr_op == los_pattern_pkg::OP_RINC)) begin
                    rd_o <= 1'b1;
                    rd_sh_r <= rd_data_i;
                end
            end
            // read data was loaded with the strobe at header end, drive from second ta bit onward
            if (rd_op_r && active_r && cnt_r == 6'd15 && fall) begin
                mdio_oe_o <= 1'b1;
                mdio_out_o <= 1'b0;
            end else if (rd_op_r && active_r && cnt_r >= 6'd16 && fall) begin
                mdio_out_o <= rd_sh_r[15];
                rd_sh_r <= {rd_sh_r[14:0], 1'b0};
            end
            if (frame_end) begin
                mdio_oe_o <= 1'b0;
                rd_op_r <= 1'b0;
                if (mine_r && fop == los_pattern_pkg::OP_ADDR) begin
                    addr_r <= sh_nxt[15:0];
                end else if (mine_r && fop == los_pattern_pkg::OP_WRITE) begin
                    wr_o <= 1'b1;
                    wr_data_o <= sh_nxt[15:0];
                end else if (mine_r && fop == los_pattern_pkg::OP_RINC) begin
                    addr_r <= addr_r + 16'h1;
                end
            end
        end
    end

    assign reg_addr_o = addr_r;
endmodule : mdio_slave
`default_nettype wire

// file: los_overlay_and_test_pattern_ctrl.sv
// loss pin overlay and test pattern control registers behind mdio
`default_nettype none
module los_overlay_and_test_pattern_ctrl (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic mdc_i,
    input wire logic mdio_in_i,
    input wire logic [4:0] port_addr_i,
    input wire los_pattern_pkg::slow_status_t slow_status_i,
    input wire logic fast_pattern_err_i,
    output logic mdio_out_o,
    output logic mdio_oe_o,
    output logic loss_indicator_pin_o,
    output var los_pattern_pkg::pattern_ctrl_t pattern_ctrl_o
);
    logic wr;
    logic rd;
    logic [15:0] reg_addr;
    logic [15:0] wr_data;
    logic mdio_out;
    logic mdio_oe;
    logic [15:0] rd_data;
    logic [15:0] overlay_r;
    logic [15:0] pattern_r;
    logic [15:0] fast_pattern_error_tally_r;
    logic [12:0] stat_s1_r;
    logic [12:0] stat_s2_r;
    logic err_s1_r;
    logic err_s2_r;
    logic loss_r;
    los_pattern_pkg::pattern_ctrl_t ctrl_r;

    mdio_slave u_mdio (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .mdc_i(mdc_i),
        .mdio_in_i(mdio_in_i),
        .port_addr_i(port_addr_i),
        .rd_data_i(rd_data),
        .mdio_out_o(mdio_out),
        .mdio_oe_o(mdio_oe),
        .wr_o(wr),
        .rd_o(rd),
        .reg_addr_o(reg_addr),
        .wr_data_o(wr_data)
    );

    // address decode
    wire sel_ovl = reg_addr == {11'h0, los_pattern_pkg::ADDR_OVERLAY};
    wire sel_pat = reg_addr == {11'h0, los_pattern_pkg::ADDR_PATTERN};
    wire sel_err = reg_addr == {11'h0, los_pattern_pkg::ADDR_ERR_TALLY};
    assign rd_data = sel_ovl ? overlay_r :
                     sel_pat ? pattern_r :
                     sel_err ? fast_pattern_error_tally_r : 16'h0000;

    // overlay field views
    wire slow_pll_unlock_to_pin = overlay_r[los_pattern_pkg::POS_PLL];
    wire [3:0] lane_sync_loss_to_pin = overlay_r[los_pattern_pkg::POS_SYNC +: 4];
    wire [3:0] lane_bad_code_to_pin = overlay_r[los_pattern_pkg::POS_CODE +: 4];
    wire [3:0] lane_signal_loss_to_pin = overlay_r[los_pattern_pkg::POS_SIG +: 4];
    los_pattern_pkg::slow_status_t st;
    assign st = stat_s2_r;

    // each enabled condition gated, then all ORed onto the pin
    wire loss_nxt = (slow_pll_unlock_to_pin & st.pll_unlock) |
                    |(lane_sync_loss_to_pin & st.sync_loss) |
                    |(lane_bad_code_to_pin & st.bad_code) |
                    |(lane_signal_loss_to_pin & st.signal_loss);

    // pattern control decode; loopback bits are stored but act elsewhere
    los_pattern_pkg::pattern_ctrl_t ctrl_nxt;
    assign ctrl_nxt.fast_pattern_gen_on = pattern_r[los_pattern_pkg::POS_FGEN];
    assign ctrl_nxt.fast_pattern_check_on = pattern_r[los_pattern_pkg::POS_FCHK];
    assign ctrl_nxt.fast_pattern_choice =
        los_pattern_pkg::pattern_code_t'(pattern_r[los_pattern_pkg::POS_FSEL +: 3]);
    assign ctrl_nxt.fast_prbs =
        los_pattern_pkg::is_prbs(pattern_r[los_pattern_pkg::POS_FSEL +: 3]);
    assign ctrl_nxt.slow_pattern_gen_on = pattern_r[los_pattern_pkg::POS_SGEN];
    assign ctrl_nxt.slow_pattern_check_on = pattern_r[los_pattern_pkg::POS_SCHK];
    wire [2:0] slow_code = {pattern_r[los_pattern_pkg::POS_SSEL_HI],
                            pattern_r[los_pattern_pkg::POS_SSEL_LO +: 2]};
    assign ctrl_nxt.slow_pattern_choice = los_pattern_pkg::pattern_code_t'(slow_code);
    assign ctrl_nxt.slow_crpat = los_pattern_pkg::is_crpat(slow_code);

    // condition and error inputs come from other domains: two flops each
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stat_s1_r <= 13'h0;
            stat_s2_r <= 13'h0;
            err_s1_r <= 1'b0;
            err_s2_r <= 1'b0;
        end else begin
            stat_s1_r <= slow_status_i;
            stat_s2_r <= stat_s1_r;
            err_s1_r <= fast_pattern_err_i;
            err_s2_r <= err_s1_r;
        end
    end

    // register writes; unmapped writes are dropped
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            overlay_r <= los_pattern_pkg::RST_OVERLAY;
            pattern_r <= los_pattern_pkg::RST_PATTERN;
        end else if (wr) begin
            if (sel_ovl) begin
                overlay_r <= wr_data;
            end
            if (sel_pat) begin
                pattern_r <= wr_data;
            end
        end
    end

    // error tally: counts while checking, saturates, clears on read of it.
    // an error in the read cycle wins, so it is never lost
    wire tally_err = ctrl_r.fast_pattern_check_on & err_s2_r;
    wire tally_clr = rd & sel_err;
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fast_pattern_error_tally_r <= 16'h0;
        end else if (tally_clr) begin
            fast_pattern_error_tally_r <= {15'h0, tally_err};
        end else if (tally_err && fast_pattern_error_tally_r != 16'hffff) begin
            fast_pattern_error_tally_r <= fast_pattern_error_tally_r + 16'h1;
        end
    end

    // outputs registered
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loss_r <= 1'b0;
            ctrl_r <= '0;
        end else begin
            loss_r <= loss_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    assign loss_indicator_pin_o = loss_r;
    assign pattern_ctrl_o = ctrl_r;
    assign mdio_out_o = mdio_out;
    assign mdio_oe_o = mdio_oe;

    AST_PLL_PIN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        slow_pll_unlock_to_pin && st.pll_unlock |=> loss_indicator_pin_o)
        else $error("pll unlock not on loss pin");
    AST_SYNC_PIN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        |(lane_sync_loss_to_pin & st.sync_loss) |=> loss_indicator_pin_o)
        else $error("sync loss not on loss pin");
    AST_CODE_PIN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        |(lane_bad_code_to_pin & st.bad_code) |=> loss_indicator_pin_o)
        else $error("bad code not on loss pin");
    AST_SIG_PIN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        |(lane_signal_loss_to_pin & st.signal_loss) |=> loss_indicator_pin_o)
        else $error("signal loss not on loss pin");
    AST_PIN_QUIET: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !(slow_pll_unlock_to_pin & st.pll_unlock) && !(|(overlay_r[11:0] & {st.sync_loss,
        st.bad_code, st.signal_loss})) |=> !loss_indicator_pin_o)
        else $error("loss pin set with no enabled condition");
    AST_FGEN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr && sel_pat |=> ##1 pattern_ctrl_o.fast_pattern_gen_on == $past(wr_data[13], 2))
        else $error("fast generation enable not applied");
    AST_FCHK: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr && sel_pat |=> ##1 pattern_ctrl_o.fast_pattern_check_on == $past(wr_data[12], 2))
        else $error("fast check enable not applied");
    AST_FSEL: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr && sel_pat |=> ##1 pattern_ctrl_o.fast_pattern_choice == $past(wr_data[10:8], 2))
        else $error("fast choice not applied");
    AST_FPRBS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pattern_ctrl_o.fast_prbs == (pattern_ctrl_o.fast_pattern_choice >= 3'h5))
        else $error("fast prbs flag wrong");
    AST_TALLY: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        tally_err && !tally_clr && fast_pattern_error_tally_r != 16'hffff
        |=> fast_pattern_error_tally_r == $past(fast_pattern_error_tally_r) + 16'h1)
        else $error("error tally did not count");
    AST_SGEN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr && sel_pat |=> ##1 pattern_ctrl_o.slow_pattern_gen_on == $past(wr_data[7], 2))
        else $error("slow generation enable not applied");
    AST_SCHK: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr && sel_pat |=> ##1 pattern_ctrl_o.slow_pattern_check_on == $past(wr_data[6], 2))
        else $error("slow check enable not applied");
    AST_SSEL: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        wr && sel_pat |=> ##1 pattern_ctrl_o.slow_pattern_choice ==
        {$past(wr_data[11], 2), $past(wr_data[5:4], 2)})
        else $error("slow choice not assembled");
    AST_SCRPAT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        pattern_ctrl_o.slow_crpat == (pattern_ctrl_o.slow_pattern_choice inside {3'h3, 3'h4}))
        else $error("slow crpat flag wrong");
    AST_SRESET: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> pattern_r[5:4] == 2'h1 && pattern_r[11] == 1'b1)
        else $error("slow choice reset wrong");

    COV_WRITE_PAT: cover property (@(posedge mclk_i) disable iff (!nrst_i) wr && sel_pat);
    COV_READ_TALLY: cover property (@(posedge mclk_i) disable iff (!nrst_i) rd && sel_err);
    COV_PIN_SET: cover property (@(posedge mclk_i) disable iff (!nrst_i)
        $rose(loss_indicator_pin_o));
    COV_TALLY_COUNT: cover property (@(posedge mclk_i) disable iff (!nrst_i) tally_err);
endmodule : los_overlay_and_test_pattern_ctrl
`default_nettype wire

// file: mdio_host_model.sv
// station management host model: clause-45 frames on a slow management clock
`default_nettype none
module mdio_host_model (
    input wire logic mclk_i,
    input wire logic mdio_wire_i,
    output logic mdc_o,
    output logic mdio_drv_o,
    output logic mdio_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // five system cycles per half period, above the synchroniser's minimum of four
    localparam int HALF = 5;

    // management clock stands still low between frames, line released
    initial begin
        mdc_o = 1'b0;
        mdio_drv_o = 1'b1;
        mdio_oe_o = 1'b0;
    end

    // data changes while the clock is low, the wire is sampled just after it rises
    task automatic send_bit(input logic b, input logic drive, output logic seen);
        @(posedge mclk_i);
        mdc_o <= 1'b0;
        mdio_drv_o <= b;
        mdio_oe_o <= drive;
        repeat (HALF) @(posedge mclk_i);
        mdc_o <= 1'b1;
        @(posedge mclk_i);
        seen = mdio_wire_i;
        repeat (HALF - 2) @(posedge mclk_i);
    endtask : send_bit

    // whole frame; on reads the host lets go of the line for turnaround and data
    task automatic frame(input logic [4:0] port, input logic [1:0] op,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [31:0] word;
        logic rd;
        logic s;
        word = {los_pattern_pkg::ST_CL45, op, port, los_pattern_pkg::DEV_ADDR, 2'b10, wdata};
        rd = op[1];
        rdata = 16'h0000;
        for (int i = 0; i < 32; i++) send_bit(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            send_bit(word[i], !(rd && i < 18), s);
            if (i < 16) rdata[i] = s;
        end
        @(posedge mclk_i);
        mdc_o <= 1'b0;
        mdio_oe_o <= 1'b0;
        repeat (HALF) @(posedge mclk_i);
    endtask : frame

    task automatic reg_write(input logic [4:0] port, input logic [4:0] addr,
                             input logic [15:0] data);
        logic [15:0] d;
        frame(port, los_pattern_pkg::OP_ADDR, {11'h000, addr}, d);
        frame(port, los_pattern_pkg::OP_WRITE, data, d);
    endtask : reg_write

    // the host judges pattern checking by reading the error tally this way
    task automatic reg_read(input logic [4:0] port, input logic [4:0] addr,
                            output logic [15:0] data);
        frame(port, los_pattern_pkg::OP_ADDR, {11'h000, addr}, data);
        frame(port, los_pattern_pkg::OP_READ, 16'h0000, data);
    endtask : reg_read
endmodule : mdio_host_model
`default_nettype wire

// file: los_overlay_and_test_pattern_ctrl_tb_top.sv
// self-checking bench for the loss overlay and test pattern control registers
`default_nettype none
module los_overlay_and_test_pattern_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] MY_PORT = 5'h03;
    logic mclk;
    logic nrst;
    logic mdc;
    logic host_drv;
    logic host_oe;
    logic dut_out;
    logic dut_oe;
    logic loss_pin;
    logic fast_err;
    logic mdio_wire;
    logic [15:0] rd;
    los_pattern_pkg::slow_status_t status;
    los_pattern_pkg::pattern_ctrl_t ctrl;
    int miscompares;
    int checks;

    // pulled-up shared line: idles high when neither side drives
    assign mdio_wire = dut_oe ? dut_out : (host_oe ? host_drv : 1'b1);

    los_overlay_and_test_pattern_ctrl dut (
        .mclk_i(mclk), .nrst_i(nrst), .mdc_i(mdc), .mdio_in_i(mdio_wire),
        .port_addr_i(MY_PORT), .slow_status_i(status), .fast_pattern_err_i(fast_err),
        .mdio_out_o(dut_out), .mdio_oe_o(dut_oe), .loss_indicator_pin_o(loss_pin),
        .pattern_ctrl_o(ctrl)
    );

    mdio_host_model host (
        .mclk_i(mclk), .mdio_wire_i(mdio_wire), .mdc_o(mdc),
        .mdio_drv_o(host_drv), .mdio_oe_o(host_oe)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_ctrl(input los_pattern_pkg::pattern_ctrl_t got,
                            input los_pattern_pkg::pattern_ctrl_t exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: pattern controls got %h expected %h", $time, got, exp);
        end
    endtask : chk_ctrl

    // decode worked out from the field layout, not from the design's helpers
    function automatic los_pattern_pkg::pattern_ctrl_t exp_ctrl(input logic [15:0] v);
        los_pattern_pkg::pattern_ctrl_t e;
        logic [2:0] s;
        s = {v[11], v[5:4]};
        e.fast_pattern_gen_on = v[13];
        e.fast_pattern_check_on = v[12];
        e.fast_pattern_choice = los_pattern_pkg::pattern_code_t'(v[10:8]);
        e.fast_prbs = v[10] & (v[9] | v[8]);
        e.slow_pattern_gen_on = v[7];
        e.slow_pattern_check_on = v[6];
        e.slow_pattern_choice = los_pattern_pkg::pattern_code_t'(s);
        e.slow_crpat = (s == 3'h3) || (s == 3'h4);
        return e;
    endfunction : exp_ctrl

    // reset values: every condition active yet the pin stays quiet
    task automatic t_reset();
        chk_ctrl(ctrl, exp_ctrl(16'h0d10));
        chk_bit(loss_pin, 1'b0, "pin after reset");
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_OVERLAY, rd);
        chk_word(rd, 16'h4000, "overlay reset");
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_PATTERN, rd);
        chk_word(rd, 16'h0d10, "pattern reset");
        $display("test reset done");
    endtask : t_reset

    // one enable at a time: all other conditions alone must not reach the pin
    task automatic t_overlay();
        for (int b = 0; b < 13; b++) begin
            host.reg_write(MY_PORT, los_pattern_pkg::ADDR_OVERLAY, 16'h4000 | (16'h1 << b));
            @(posedge mclk);
            status <= los_pattern_pkg::slow_status_t'(~(13'h1 << b));
            repeat (5) @(posedge mclk);
            chk_bit(loss_pin, 1'b0, "pin with only masked conditions");
            status <= los_pattern_pkg::slow_status_t'(13'h1 << b);
            repeat (5) @(posedge mclk);
            chk_bit(loss_pin, 1'b1, "pin with enabled condition");
        end
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_OVERLAY, rd);
        chk_word(rd, 16'h5000, "overlay readback");
        $display("test overlay done");
    endtask : t_overlay

    // every selector code on both sides, enables in all four combinations
    task automatic t_pattern();
        logic [2:0] c;
        logic [2:0] s;
        logic [15:0] v;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            s = 3'(7 - i);
            v = {2'b10, c[0], c[1], s[2], c, c[1], c[0], s[1:0], 4'h5};
            host.reg_write(MY_PORT, los_pattern_pkg::ADDR_PATTERN, v);
            repeat (3) @(posedge mclk);
            chk_ctrl(ctrl, exp_ctrl(v));
        end
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_PATTERN, rd);
        chk_word(rd, v, "pattern readback");
        $display("test pattern done");
    endtask : t_pattern

    // errors count only while fast checking is on
    task automatic t_tally();
        host.reg_write(MY_PORT, los_pattern_pkg::ADDR_PATTERN, 16'h1d10);
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_ERR_TALLY, rd);
        @(posedge mclk);
        fast_err <= 1'b1;
        repeat (6) @(posedge mclk);
        fast_err <= 1'b0;
        repeat (5) @(posedge mclk);
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_ERR_TALLY, rd);
        chk_word(rd, 16'h0006, "error tally");
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_ERR_TALLY, rd);
        chk_word(rd, 16'h0000, "tally after read");
        host.reg_write(MY_PORT, los_pattern_pkg::ADDR_PATTERN, 16'h0d10);
        @(posedge mclk);
        fast_err <= 1'b1;
        repeat (3) @(posedge mclk);
        fast_err <= 1'b0;
        repeat (5) @(posedge mclk);
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_ERR_TALLY, rd);
        chk_word(rd, 16'h0000, "tally with check off");
        $display("test tally done");
    endtask : t_tally

    // a frame for another port changes nothing; an unmapped place reads zero
    task automatic t_refuse();
        host.reg_write(5'h04, los_pattern_pkg::ADDR_OVERLAY, 16'h0fff);
        host.reg_read(MY_PORT, los_pattern_pkg::ADDR_OVERLAY, rd);
        chk_word(rd, 16'h5000, "overlay after foreign write");
        // read-increment returns the overlay, then the address moves to the pattern register
        host.frame(MY_PORT, los_pattern_pkg::OP_RINC, 16'h0000, rd);
        chk_word(rd, 16'h5000, "read-increment data");
        host.frame(MY_PORT, los_pattern_pkg::OP_READ, 16'h0000, rd);
        chk_word(rd, los_pattern_pkg::RST_PATTERN, "read after increment");
        host.reg_read(MY_PORT, 5'h05, rd);
        chk_word(rd, 16'h0000, "unmapped read");
        $display("test refuse done");
    endtask : t_refuse

    // main sequence
    initial begin
        miscompares = 0;
        checks = 0;
        nrst = 1'b0;
        fast_err = 1'b0;
        status = los_pattern_pkg::slow_status_t'(13'h1fff);
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        t_reset();
        t_overlay();
        t_pattern();
        t_tally();
        t_refuse();
        close_out();
    end

    // watchdog: roughly twice the expected run of about forty-five thousand cycles
    initial begin
        repeat (90000) @(posedge mclk);
        miscompares++;
        $display("Error at %0t: run did not finish in time", $time);
        close_out();
    end
endmodule : los_overlay_and_test_pattern_ctrl_tb_top
`default_nettype wire
